/* File: hw/bmp_regs.vh */
// Constants for the bus-master memory protection unit and CPU state logic.
// Assumes inclusion by bare name from design files under hw/.
// What this block does
// R1 - Eight identical access descriptors control all masters
// R2 - Disallowed access raises a non-maskable interrupt
// R3 - Four master identities: two CPU, coprocessor, other
// R4 - CPU identity follows supervisor or user state
// R5 - User-state flag sits at condition code bit 15
// R6 - Kernel call raises its own non-maskable trap
// R7 - Supervisor setting the flag enters user state
// R8 - User state cannot touch masks, stop, priority
// R9 - User-state flag writes update unprotected bits only
// R10 - Idle pause and stop act as no-op in user
// R11 - Supervisor accesses checked only when check enabled
// R12 - Interrupt entry stacks flag set, then clears it
// R13 - Trap return restores flag from stacked word
// R14 - Access outside assigned descriptors is denied
// R15 - Descriptor bounds are 20 bits, 8-byte granularity
// R16 - Descriptor active when assigned to any master
// R17 - Separate write-prohibit and execute-prohibit per descriptor
// R18 - After reset descriptor 0 grants full access
// R19 - Debug port accesses bypass all checking
// R20 - Any permitting overlapping descriptor allows the access
`ifndef BMP_REGS_VH
`define BMP_REGS_VH

// Register byte offsets
`define BMP_OFS_SELECT      8'h00
`define BMP_OFS_STATUS      8'h04
`define BMP_OFS_VADDR       8'h08
`define BMP_OFS_CCR         8'h0C
`define BMP_DESC_BASE_BIT   7
`define BMP_DESC_FLD_START  2'h0
`define BMP_DESC_FLD_END    2'h1
`define BMP_DESC_FLD_CTRL   2'h2

// Field positions
`define BMP_SEL_KCE_BIT     0
`define BMP_ST_VIOL_BIT     0
`define BMP_CTRL_WP_BIT     4
`define BMP_CTRL_XP_BIT     5

// Reset values
`define BMP_DESC0_START     20'h00000
`define BMP_DESC0_END       20'hFFFFF
`define BMP_DESC0_MASTERS   4'hF
`define BMP_CCR_RESET       16'h00D0

// Master identities
`define BMP_MID_KERNEL      2'h0
`define BMP_MID_APP         2'h1
`define BMP_MID_COPROC      2'h2
`define BMP_MID_OTHER       2'h3

// Condition code bit positions and protected mask
`define BMP_CCR_U_BIT       15
`define BMP_CCR_S_BIT       7
`define BMP_CCR_I_BIT       4
`define BMP_CCR_PROT_MASK   16'h87D0

// Instruction kinds on the CPU op port
`define BMP_OP_MASK_RELEASE 4'h0
`define BMP_OP_MASK_ASSERT  4'h1
`define BMP_OP_FLAG_AND     4'h2
`define BMP_OP_FLAG_OR      4'h3
`define BMP_OP_TRAP_RETURN  4'h4
`define BMP_OP_FLAG_POP     4'h5
`define BMP_OP_REG_SWAP     4'h6
`define BMP_OP_REG_COPY     4'h7
`define BMP_OP_IDLE_PAUSE   4'h8
`define BMP_OP_STOP         4'h9
`define BMP_OP_KERNEL_CALL  4'hA
`define BMP_OP_SOFT_TRAP    4'hB

// Bus answers
`define BMP_RESP_OKAY       2'h0
`define BMP_RESP_SLVERR     2'h2

`endif

/* File: hw/bmp_desc_match.v */
// One access descriptor comparator: range, assignment and permission check.
// Assumes page and master are stable in the cycle the result is used.
`timescale 1ns/1ns
module bmp_desc_match (
    input  wire [19:0] d_start,   // First page
    input  wire [19:0] d_end,     // Last page
    input  wire [3:0]  d_masters, // Masters
    input  wire        d_wp,      // No write
    input  wire        d_xp,      // No fetch
    input  wire [1:0]  master,    // Requester
    input  wire [19:0] page,      // Access page
    input  wire        is_write,  // Write
    input  wire        is_exec,   // Fetch
    output wire        permit     // Allowed here
);
    wire active;   // Assigned
    wire covers;   // In bounds
    wire assigned; // Requester assigned
    wire type_ok;  // Kind allowed

    // Unassigned descriptors never grant anything
    assign active   = |d_masters; // R16
    assign covers   = (page >= d_start) && (page <= d_end); // R15
    assign assigned = d_masters[master]; // R16
    // Read always allowed inside range; write and fetch gated separately
    assign type_ok  = !(is_write && d_wp) && !(is_exec && d_xp); // R17
    assign permit   = active && covers && assigned && type_ok;
endmodule

/* File: hw/bmp_top.v */
// Memory protection unit with CPU privilege-state logic and AXI4-Lite registers.
// Assumes one access check offered per cycle, synchronous to ref_clk.
//
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ns
`include "bmp_regs.vh"
module bmp_top #(
    parameter N_DESC = 8,  // Descriptor count
    parameter ADDR_W = 8   // Register bus address width
) (
    input  wire              ref_clk,         // Clock
    input  wire              nrst,            // Sync reset
    // AXI4-Lite slave
    input  wire [ADDR_W-1:0] s_axi_awaddr,    // AW addr
    input  wire              s_axi_awvalid,   // AW valid
    output reg               s_axi_awready,   // AW ready
    input  wire [31:0]       s_axi_wdata,     // W data
    input  wire [3:0]        s_axi_wstrb,     // Byte enables
    input  wire              s_axi_wvalid,    // W valid
    output reg               s_axi_wready,    // W ready
    output reg  [1:0]        s_axi_bresp,     // B resp
    output reg               s_axi_bvalid,    // B valid
    input  wire              s_axi_bready,    // B ready
    input  wire [ADDR_W-1:0] s_axi_araddr,    // AR addr
    input  wire              s_axi_arvalid,   // AR valid
    output reg               s_axi_arready,   // AR ready
    output reg  [31:0]       s_axi_rdata,     // R data
    output reg  [1:0]        s_axi_rresp,     // R resp
    output reg               s_axi_rvalid,    // R valid
    input  wire              s_axi_rready,    // R ready
    // Access check port
    input  wire              acc_valid,       // Check request
    input  wire              acc_from_cpu,    // From CPU
    input  wire [1:0]        acc_master,      // Non-CPU identity
    input  wire [22:0]       acc_addr,        // Byte address
    input  wire              acc_write,       // Write
    input  wire              acc_exec,        // Fetch
    input  wire              debug_port_access, // Debug path
    output reg               acc_done,        // Result valid
    output reg               acc_allowed,     // Result
    output reg               nmi_violation,   // Violation NMI
    // CPU flag port
    input  wire              op_valid,        // Op executes
    input  wire [3:0]        op_kind,         // Op kind
    input  wire [15:0]       op_src,          // Operand
    input  wire              irq_enter,       // Handler entry
    output reg  [15:0]       condition_code_register, // Flags
    output reg  [15:0]       stack_word,      // Pushed word
    output reg               stack_push,      // Push pulse
    output reg               kernel_call_op,  // Kernel call
    output reg               soft_trap_op,    // Soft trap
    output reg               idle_pause_op,   // Wait pulse
    output reg               stop_req         // Stop pulse
);
    // Descriptor storage, flattened so the generate loop can slice it
    reg  [N_DESC*20-1:0] start_flat;  // Starts
    reg  [N_DESC*20-1:0] end_flat;    // Ends
    reg  [N_DESC*4-1:0]  mask_flat;   // Masters
    reg  [N_DESC-1:0]    wp_vec;      // No write
    reg  [N_DESC-1:0]    xp_vec;      // No fetch
    reg                  kernel_check_enable; // Check kernel
    reg                  viol_flag;   // Sticky flag
    reg  [1:0]           viol_master; // Last master
    reg                  viol_write;  // Last write
    reg                  viol_exec;   // Last fetch
    reg  [22:0]          viol_addr;   // Last address

    // Write channel state
    reg  [ADDR_W-1:0]    aw_addr;     // Held addr
    reg                  aw_held;     // Addr held
    reg  [31:0]          w_data;      // Held data
    reg  [3:0]           w_strb;      // Held strobes
    reg                  w_held;      // Data held

    wire [1:0]           cur_master;  // Identity
    wire [N_DESC-1:0]    permit_vec;  // Permits
    wire                 unchecked;   // No check
    wire                 allow_now;   // Decision
    wire                 user_state;  // User state
    wire                 wr_fire;     // Write now
    wire                 wr_is_desc;  // Descriptor write
    wire [2:0]           wr_idx;      // Write index
    wire [1:0]           wr_fld;      // Write field
    wire                 wr_ok;       // Mapped write
    wire                 viol_clr;    // Flag clear
    wire                 viol_set;    // Violation
    wire [2:0]           rd_idx;      // Read index
    reg  [31:0]          rd_val;      // Read word
    reg                  rd_ok;       // Mapped read
    reg  [31:0]          wr_old;      // Old word

    assign user_state = condition_code_register[`BMP_CCR_U_BIT]; // R5
    // CPU identity follows the privilege state
    assign cur_master = acc_from_cpu ? (user_state ? `BMP_MID_APP : `BMP_MID_KERNEL)
                                     : acc_master; // R3 R4

    // One comparator per descriptor
    genvar gi;
    generate
        for (gi = 0; gi < N_DESC; gi = gi + 1) begin : g_desc
            bmp_desc_match u_match (
                .d_start   (start_flat[gi*20 +: 20]),
                .d_end     (end_flat[gi*20 +: 20]),
                .d_masters (mask_flat[gi*4 +: 4]),
                .d_wp      (wp_vec[gi]),
                .d_xp      (xp_vec[gi]),
                .master    (cur_master),
                .page      (acc_addr[22:3]),
                .is_write  (acc_write),
                .is_exec   (acc_exec),
                .permit    (permit_vec[gi])
            ); // R1
        end
    endgenerate

    // Debug and unchecked supervisor accesses skip the descriptors
    assign unchecked = debug_port_access || // R19
                       (cur_master == `BMP_MID_KERNEL && !kernel_check_enable); // R11
    // Any permitting descriptor is enough; none means denied
    assign allow_now = unchecked || (|permit_vec); // R14 R20
    assign viol_set  = acc_valid && !allow_now;

    // Check result and interrupt, registered one cycle after the request
    always @(posedge ref_clk) begin
        if (!nrst) begin
            acc_done      <= 1'b0;
            acc_allowed   <= 1'b0;
            nmi_violation <= 1'b0;
        end else begin
            acc_done      <= acc_valid;
            acc_allowed   <= acc_valid && allow_now;
            nmi_violation <= viol_set; // R2
        end
    end

    // Violation capture; a new violation beats a same-cycle clear
    always @(posedge ref_clk) begin
        if (!nrst) begin
            viol_flag   <= 1'b0;
            viol_master <= 2'h0;
            viol_write  <= 1'b0;
            viol_exec   <= 1'b0;
            viol_addr   <= 23'h000000;
        end else begin
            viol_flag <= viol_set || (viol_flag && !viol_clr);
            if (viol_set) begin
                viol_master <= cur_master;
                viol_write  <= acc_write;
                viol_exec   <= acc_exec;
                viol_addr   <= acc_addr;
            end
        end
    end

    // Byte-enable merge of a register word
    function [31:0] merge_strb;
        input [31:0] old_w;
        input [31:0] new_w;
        input [3:0]  strb;
        integer k;
        begin
            for (k = 0; k < 4; k = k + 1)
                merge_strb[k*8 +: 8] = strb[k] ? new_w[k*8 +: 8] : old_w[k*8 +: 8];
        end
    endfunction

    // Write decode
    assign wr_fire    = aw_held && w_held && !s_axi_bvalid;
    assign wr_is_desc = aw_addr[`BMP_DESC_BASE_BIT];
    assign wr_idx     = aw_addr[6:4];
    assign wr_fld     = aw_addr[3:2];
    assign wr_ok      = wr_is_desc ? (wr_fld != 2'h3)
                                   : (aw_addr == `BMP_OFS_SELECT ||
                                      aw_addr == `BMP_OFS_STATUS);
    assign viol_clr   = wr_fire && !wr_is_desc && aw_addr == `BMP_OFS_STATUS &&
                        w_strb[0] && w_data[`BMP_ST_VIOL_BIT];

    // Current contents at the write address, for byte merging
    always @* begin
        wr_old = 32'h00000000;
        case (wr_fld)
            `BMP_DESC_FLD_START: wr_old = {12'h000, start_flat[wr_idx*20 +: 20]};
            `BMP_DESC_FLD_END:   wr_old = {12'h000, end_flat[wr_idx*20 +: 20]};
            `BMP_DESC_FLD_CTRL:  wr_old = {26'h0000000, xp_vec[wr_idx], wp_vec[wr_idx],
                                           mask_flat[wr_idx*4 +: 4]};
            default:             wr_old = 32'h00000000;
        endcase
    end

    // AXI write channels: address and data taken in either order
    always @(posedge ref_clk) begin
        if (!nrst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `BMP_RESP_OKAY;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= {ADDR_W{1'b0}};
            w_data        <= 32'h00000000;
            w_strb        <= 4'h0;
        end else begin
            // Each ready only while its own channel holds nothing, so a held beat is never overwritten
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr <= s_axi_awaddr;
                aw_held <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                w_held <= 1'b1;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `BMP_RESP_OKAY : `BMP_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
            end
        end
    end

    // Descriptor and select register storage
    always @(posedge ref_clk) begin : p_desc
        reg [31:0] mw; // Merged write word
        mw = merge_strb(wr_old, w_data, w_strb);
        if (!nrst) begin
            // Descriptor 0 covers everything for every master
            start_flat <= {(N_DESC*20){1'b0}}; // R18
            end_flat   <= {{((N_DESC-1)*20){1'b0}}, `BMP_DESC0_END}; // R18
            mask_flat  <= {{((N_DESC-1)*4){1'b0}}, `BMP_DESC0_MASTERS}; // R18
            wp_vec     <= {N_DESC{1'b0}};
            xp_vec     <= {N_DESC{1'b0}};
            kernel_check_enable <= 1'b0;
        end else if (wr_fire && wr_is_desc) begin
            case (wr_fld)
                `BMP_DESC_FLD_START: start_flat[wr_idx*20 +: 20] <= mw[19:0]; // R15
                `BMP_DESC_FLD_END:   end_flat[wr_idx*20 +: 20]   <= mw[19:0]; // R15
                `BMP_DESC_FLD_CTRL: begin
                    mask_flat[wr_idx*4 +: 4] <= mw[3:0];
                    wp_vec[wr_idx]           <= mw[`BMP_CTRL_WP_BIT]; // R17
                    xp_vec[wr_idx]           <= mw[`BMP_CTRL_XP_BIT]; // R17
                end
                default: ; // Unmapped field, answered with an error
            endcase
        end else if (wr_fire && aw_addr == `BMP_OFS_SELECT && w_strb[0]) begin
            kernel_check_enable <= w_data[`BMP_SEL_KCE_BIT]; // R11
        end
    end

    // Read mux
    assign rd_idx = s_axi_araddr[6:4];
    always @* begin
        rd_val = 32'h00000000;
        rd_ok  = 1'b1;
        if (s_axi_araddr[`BMP_DESC_BASE_BIT]) begin
            case (s_axi_araddr[3:2])
                `BMP_DESC_FLD_START: rd_val = {12'h000, start_flat[rd_idx*20 +: 20]};
                `BMP_DESC_FLD_END:   rd_val = {12'h000, end_flat[rd_idx*20 +: 20]};
                `BMP_DESC_FLD_CTRL:  rd_val = {26'h0000000, xp_vec[rd_idx], wp_vec[rd_idx],
                                               mask_flat[rd_idx*4 +: 4]};
                default:             rd_ok  = 1'b0;
            endcase
        end else begin
            case (s_axi_araddr)
                `BMP_OFS_SELECT: rd_val = {31'h00000000, kernel_check_enable};
                `BMP_OFS_STATUS: rd_val = {24'h000000, viol_exec, viol_write,
                                           viol_master, 3'h0, viol_flag};
                `BMP_OFS_VADDR:  rd_val = {9'h000, viol_addr};
                `BMP_OFS_CCR:    rd_val = {16'h0000, condition_code_register};
                default:         rd_ok  = 1'b0;
            endcase
        end
    end

    // AXI read channel: one read at a time, data one cycle after the address
    always @(posedge ref_clk) begin
        if (!nrst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `BMP_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_val;
                s_axi_rresp  <= rd_ok ? `BMP_RESP_OKAY : `BMP_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Protected bits keep their value while in user state
    function [15:0] guard_ccr;
        input [15:0] old_c;
        input [15:0] cand;
        begin
            if (old_c[`BMP_CCR_U_BIT])
                guard_ccr = (old_c & `BMP_CCR_PROT_MASK) | (cand & ~`BMP_CCR_PROT_MASK); // R8 R9
            else
                guard_ccr = cand; // R7
        end
    endfunction

    // Condition code update; interrupt entry wins over a same-cycle op
    always @(posedge ref_clk) begin : p_ccr
        reg [15:0] cand; // Unguarded new value
        reg        trap; // Op enters a trap handler
        cand = condition_code_register;
        trap = 1'b0;
        case (op_kind)
            `BMP_OP_MASK_RELEASE: cand[`BMP_CCR_I_BIT] = 1'b0;
            `BMP_OP_MASK_ASSERT:  cand[`BMP_CCR_I_BIT] = 1'b1;
            `BMP_OP_FLAG_AND:     cand = condition_code_register & op_src;
            `BMP_OP_FLAG_OR:      cand = condition_code_register | op_src;
            `BMP_OP_TRAP_RETURN:  cand = op_src; // R13
            `BMP_OP_FLAG_POP:     cand = op_src;
            `BMP_OP_REG_SWAP:     cand = op_src;
            `BMP_OP_REG_COPY:     cand = op_src;
            `BMP_OP_KERNEL_CALL:  trap = 1'b1;
            `BMP_OP_SOFT_TRAP:    trap = 1'b1;
            default:              cand = condition_code_register;
        endcase
        if (!nrst) begin
            condition_code_register <= `BMP_CCR_RESET;
            stack_word     <= 16'h0000;
            stack_push     <= 1'b0;
            kernel_call_op <= 1'b0;
            soft_trap_op   <= 1'b0;
            idle_pause_op  <= 1'b0;
            stop_req       <= 1'b0;
        end else begin
            stack_push     <= 1'b0;
            kernel_call_op <= 1'b0;
            soft_trap_op   <= 1'b0;
            idle_pause_op  <= 1'b0;
            stop_req       <= 1'b0;
            if (irq_enter || (op_valid && trap)) begin
                // Stack with the flag as it stands, then run as supervisor
                stack_word <= condition_code_register; // R12
                stack_push <= 1'b1;
                condition_code_register[`BMP_CCR_U_BIT] <= 1'b0; // R12
                kernel_call_op <= !irq_enter && op_kind == `BMP_OP_KERNEL_CALL; // R6
                soft_trap_op   <= !irq_enter && op_kind == `BMP_OP_SOFT_TRAP;
            end else if (op_valid) begin
                condition_code_register <= guard_ccr(condition_code_register, cand); // R9
                // Wait and stop are ignored in user state
                idle_pause_op <= op_kind == `BMP_OP_IDLE_PAUSE && !user_state; // R10
                stop_req      <= op_kind == `BMP_OP_STOP && !user_state &&
                                 !condition_code_register[`BMP_CCR_S_BIT]; // R10
            end
        end
    end
endmodule

/* File: testbench/bmp_properties.sv */
// Checker: access answers, CPU flags.
// Bound to bmp_top; sees its ports.
`timescale 1ns/1ns
module bmp_props (
    input wire        ref_clk, nrst, acc_valid, debug_port_access, // Clock, request
    input wire        acc_done, acc_allowed, nmi_violation,  // Answer
    input wire        op_valid, irq_enter, stack_push,       // Events
    input wire        kernel_call_op, idle_pause_op,         // Pulses
    input wire [3:0]  op_kind,                               // Op kind
    input wire [15:0] condition_code_register, stack_word    // Flags
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    localparam [15:0] PROT = 16'h87D0; // Guarded flags
    wire usr = condition_code_register[15]; // User state
    // Push, handler in supervisor
    sequence s_stk; stack_push && !condition_code_register[15]; endsequence
    property p_done; acc_valid |=> acc_done; endproperty
    property p_quiet; !acc_valid |=> !acc_done && !nmi_violation; endproperty
    property p_nmi; acc_done |-> nmi_violation == !acc_allowed; endproperty
    property p_dbg; acc_valid && debug_port_access |=> acc_allowed && !nmi_violation; endproperty
    property p_entry;
        irq_enter |=> s_stk ##0 stack_word == $past(condition_code_register); endproperty
    property p_guard; op_valid && !irq_enter && usr && op_kind < 4'hA |=>
        (condition_code_register & PROT) == ($past(condition_code_register) & PROT); endproperty
    property p_nop; op_valid && !irq_enter && usr && op_kind == 4'h8 |=> !idle_pause_op;
    endproperty
    property p_call; op_valid && !irq_enter && op_kind == 4'hA |=> s_stk ##0 kernel_call_op;
    endproperty
    a_done: assert property (p_done) else $error("no answer");
    a_quiet: assert property (p_quiet) else $error("stray answer");
    a_nmi: assert property (p_nmi) else $error("nmi mismatch");
    a_dbg: assert property (p_dbg) else $error("debug blocked");
    a_entry: assert property (p_entry) else $error("bad entry");
    a_guard: assert property (p_guard) else $error("guard broken");
    a_nop: assert property (p_nop) else $error("user pause");
    a_call: assert property (p_call) else $error("no call");
endmodule
bind bmp_top bmp_props u_props (.ref_clk, .nrst, .acc_valid, .debug_port_access, .acc_done,
    .acc_allowed, .nmi_violation, .op_valid, .irq_enter, .stack_push, .kernel_call_op,
    .idle_pause_op, .op_kind, .condition_code_register, .stack_word);

/* File: testbench/bmp_mst.sv */
// Far-side bus master, one check at a time.
// Assumes a one-cycle answer.
`timescale 1ns/1ns
module bmp_mst (
    input wire        ref_clk, acc_done, acc_allowed, nmi_violation, // Clock and answer
    output reg        acc_valid = 0, acc_from_cpu = 0, acc_write = 0, // Request, CPU, write
    output reg        acc_exec = 0, debug_port_access = 0,            // Fetch, debug path
    output reg [1:0]  acc_master = 0,                                 // Non-CPU identity
    output reg [22:0] acc_addr = 0                                    // Global byte address
);
    // One access, then its answer
    task go(input c, input [1:0] m, input [22:0] a, input w, x, d, output [2:0] r);
        begin
            @(posedge ref_clk);
            {acc_valid, acc_from_cpu, acc_master, acc_write, acc_exec} <= {2'b1, c, m, w, x};
            debug_port_access <= d;
            acc_addr <= a;
            @(posedge ref_clk);
            acc_valid <= 0;
            acc_addr <= ~a; // No stale address
            #1 r = {acc_done, acc_allowed, nmi_violation};
        end
    endtask
endmodule

/* File: testbench/bmp_tb_top.sv */
// Bench: register bus, access checks, CPU events.
// Assumes design and model compiled first.
`timescale 1ns/1ns
module bmp_tb_top;
    reg ref_clk = 0, nrst = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    reg s_axi_arvalid = 0, s_axi_rready = 0, op_valid = 0, irq_enter = 0;
    reg [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    reg [31:0] s_axi_wdata = 0;
    reg [3:0] op_kind = 0;
    reg [15:0] op_src = 0;
    reg [2:0] res;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, acc_valid;
    wire acc_from_cpu, acc_write, acc_exec, debug_port_access, acc_done, acc_allowed;
    wire nmi_violation, stack_push, kernel_call_op, soft_trap_op, idle_pause_op, stop_req;
    wire [1:0] s_axi_bresp, s_axi_rresp, acc_master;
    wire [31:0] s_axi_rdata;
    wire [22:0] acc_addr;
    wire [15:0] condition_code_register, stack_word;
    integer err_total = 0, checked = 0, cyc = 0;
    bmp_top dut (.ref_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .acc_valid, .acc_from_cpu,
        .acc_master, .acc_addr, .acc_write, .acc_exec, .debug_port_access, .acc_done,
        .acc_allowed, .nmi_violation, .op_valid, .op_kind, .op_src, .irq_enter,
        .condition_code_register, .stack_word, .stack_push, .kernel_call_op, .soft_trap_op,
        .idle_pause_op, .stop_req);
    bmp_mst mst (.ref_clk, .acc_done, .acc_allowed, .nmi_violation, .acc_valid,
        .acc_from_cpu, .acc_write, .acc_exec, .debug_port_access, .acc_master, .acc_addr);
    initial forever #50 ref_clk = ~ref_clk; // 10 MHz
    task conclude; begin
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    end endtask
    // Hang guard, tests need ~100
    always @(posedge ref_clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin err_total = err_total + 1; $display("BAD %0t hang", $time);
            conclude; end
    end
    task chk(input [33:0] g, e); begin checked = checked + 1;
        if (g !== e) begin err_total = err_total + 1; $display("BAD %0t got %h exp %h", $time, g, e); end
    end endtask
    task wr(input [7:0] a, input [31:0] d); begin
        @(posedge ref_clk); {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        s_axi_awaddr <= a; s_axi_wdata <= d;
        do begin @(posedge ref_clk); if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0; end while (!s_axi_bvalid);
        s_axi_bready <= 0; chk(s_axi_bresp, 0);
    end endtask
    task rchk(input [7:0] a, input [1:0] r, input [31:0] e); begin
        @(posedge ref_clk); s_axi_arvalid <= 1; s_axi_rready <= 1; s_axi_araddr <= a;
        do begin @(posedge ref_clk); if (s_axi_arready) s_axi_arvalid <= 0; end
        while (!s_axi_rvalid);
        s_axi_rready <= 0; chk({s_axi_rresp, s_axi_rdata}, {r, e});
    end endtask
    task acc(input c, input [1:0] m, input [22:0] a, input w, x, d, input [2:0] e);
        begin mst.go(c, m, a, w, x, d, res); chk(res, e); end endtask
    // One CPU event, flags and pulses
    task ev(input i, input [3:0] k, input [15:0] s, e, input [4:0] p); begin
        @(posedge ref_clk); irq_enter <= i; op_valid <= !i; op_kind <= k; op_src <= s;
        @(posedge ref_clk); irq_enter <= 0; op_valid <= 0;
        #1 chk({condition_code_register, stack_push, kernel_call_op, soft_trap_op,
            idle_pause_op, stop_req}, {e, p});
    end endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        nrst <= 1;
        rchk(8'h88, 0, 32'hF);
        rchk(8'h84, 0, 32'hFFFFF);
        rchk(8'h0C, 0, 32'hD0);
        rchk(8'h10, 2, 0);
        acc(0, 3, 23'h7FFFF8, 1, 1, 0, 3'b110);
        wr(8'h88, 32'h4); wr(8'h90, 32'h10); wr(8'h94, 32'h1F); wr(8'h98, 32'h18);
        acc(0, 3, 23'h80, 0, 0, 0, 3'b110);
        acc(0, 3, 23'hF8, 0, 1, 0, 3'b110);
        acc(0, 3, 23'hF8, 1, 0, 0, 3'b101);
        acc(0, 3, 23'h100, 0, 0, 0, 3'b101);
        acc(0, 3, 23'h100, 1, 0, 1, 3'b110);
        acc(0, 2, 23'h100, 1, 1, 0, 3'b110);
        acc(1, 0, 23'h100, 1, 0, 0, 3'b110);
        wr(8'h00, 32'h1); wr(8'h98, 32'h3A); wr(8'hA0, 32'h10); wr(8'hA4, 32'h1F);
        wr(8'hA8, 32'h8);
        acc(1, 0, 23'h80, 0, 0, 0, 3'b101);
        acc(0, 3, 23'h80, 1, 1, 0, 3'b110);
        ev(0, 4'h3, 16'h8000, 16'h80D0, 0);
        acc(1, 0, 23'h80, 0, 0, 0, 3'b110);
        ev(0, 4'h4, 16'h000F, 16'h80DF, 0);
        ev(0, 4'h0, 0, 16'h80DF, 0);
        ev(0, 4'h8, 0, 16'h80DF, 0);
        ev(0, 4'h9, 0, 16'h80DF, 0);
        ev(1, 0, 0, 16'h00DF, 5'b10000);
        chk(stack_word, 16'h80DF);
        ev(0, 4'h4, 16'h80DF, 16'h80DF, 0);
        ev(0, 4'hA, 0, 16'h00DF, 5'b11000);
        ev(0, 4'hB, 0, 16'h00DF, 5'b10100);
        ev(0, 4'h8, 0, 16'h00DF, 5'b00010);
        ev(0, 4'h2, 16'hFF7F, 16'h005F, 0);
        ev(0, 4'h9, 0, 16'h005F, 5'b00001);
        conclude;
    end
endmodule
